// file: verilog/acm_pkg.sv
// constants, register map and configuration carrier for the converter control map
package acm_pkg;

  // register offsets on the serial control port
  localparam logic [12:0] ACM_ADDR_INDEX_A = 13'h004;
  localparam logic [12:0] ACM_ADDR_INDEX_B = 13'h005;
  localparam logic [12:0] ACM_ADDR_PAT1_LO = 13'h019;
  localparam logic [12:0] ACM_ADDR_PAT1_HI = 13'h01a;
  localparam logic [12:0] ACM_ADDR_PAT2_LO = 13'h01b;
  localparam logic [12:0] ACM_ADDR_PAT2_HI = 13'h01c;
  localparam logic [12:0] ACM_ADDR_SERIAL = 13'h021;
  localparam logic [12:0] ACM_ADDR_CHAN = 13'h022;
  localparam logic [12:0] ACM_ADDR_XFER = 13'h0ff;
  localparam logic [12:0] ACM_ADDR_RATE = 13'h100;
  localparam logic [12:0] ACM_ADDR_IO_B = 13'h101;
  localparam logic [12:0] ACM_ADDR_IO_C = 13'h102;
  localparam logic [12:0] ACM_ADDR_SYNC = 13'h109;

  // reset values
  localparam logic [7:0] ACM_RST_ZERO = 8'h00;
  localparam logic [7:0] ACM_RST_SERIAL = 8'h41;
  localparam logic [3:0] ACM_RST_INDEX_A = 4'hf;
  localparam logic [5:0] ACM_RST_INDEX_B = 6'h0f;

  // field positions
  localparam int ACM_SER_LSB_FIRST = 7;
  localparam logic [1:0] ACM_RES_14 = 2'h1;
  localparam int ACM_CH_OUT_RESET = 1;
  localparam int ACM_CH_POWER_DOWN = 0;
  localparam int ACM_RATE_EN = 6;
  localparam int ACM_XFER_GO = 0;
  localparam int ACM_IOB_PULL_OFF = 0;
  localparam int ACM_IOC_VCM_PD = 3;
  localparam int ACM_SYNC_EN = 0;
  localparam int ACM_SYNC_NEXT = 1;
  localparam int ACM_IDX_FCO = 4;
  localparam int ACM_IDX_DCO = 5;
  localparam logic [7:0] ACM_RATE_MASK = 8'h47;

  // channel numbering: 0..7 data lanes, 8 frame clock, 9 data clock
  localparam int ACM_NCH = 10;
  localparam int ACM_NDATA = 8;

  // sample rate codes and their rates in MSPS
  localparam logic [2:0] ACM_RATE_20 = 3'h0;
  localparam logic [2:0] ACM_RATE_40 = 3'h1;
  localparam logic [2:0] ACM_RATE_50 = 3'h2;
  localparam logic [2:0] ACM_RATE_65 = 3'h3;
  localparam logic [7:0] ACM_MSPS_20 = 8'h14;
  localparam logic [7:0] ACM_MSPS_40 = 8'h28;
  localparam logic [7:0] ACM_MSPS_50 = 8'h32;
  localparam logic [7:0] ACM_MSPS_65 = 8'h41;

  // serial frame: instruction bits and frame end
  localparam logic [4:0] ACM_INSTR_LAST = 5'h0f;
  localparam logic [4:0] ACM_DATA_FIRST = 5'h10;
  localparam logic [4:0] ACM_DATA_LAST = 5'h17;
  localparam logic [4:0] ACM_FRAME_DONE = 5'h18;

  // live configuration driven into the converter
  typedef struct packed {
    logic [15:0] pattern_one;
    logic [15:0] pattern_two;
    logic [7:0] serial;
    logic lsb_first;
    logic res14;
    logic [ACM_NCH-1:0] chan_out_reset;
    logic [ACM_NCH-1:0] chan_power_down;
    logic rate_en;
    logic [2:0] rate_code;
    logic sdio_pull_off;
    logic vcm_power_down;
    logic sync_enable;
    logic sync_next_only;
  } acm_cfg_t;

endpackage

// file: verilog/acm_spi_port.sv
// serial control port front end: pin sampling, framing, read shift-out
`timescale 1ns/1ns
`default_nettype none
module acm_spi_port
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic sdio_i,
  input wire logic [7:0] rdata_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic wr_o,
  output logic [12:0] addr_o,
  output logic [7:0] wdata_o
);

  logic [2:0] sclk_q, csb_q, sdio_q;
  logic [4:0] cnt, next_cnt;
  logic [15:0] instr, next_instr;
  logic rd, next_rd;
  logic load_pend, next_load_pend;
  logic [7:0] data_sh, next_data_sh;
  logic [7:0] tx, next_tx;
  logic next_sdio, next_oe, next_wr;
  logic [12:0] next_addr;
  logic [7:0] next_wdata;
  logic rise, fall, active, bit_in;

  // three-stage pin sampling; only stages two and three are looked at
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 3'h0;
      csb_q <= 3'h7;
      sdio_q <= 3'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      csb_q <= {csb_q[1:0], csb_n_i};
      sdio_q <= {sdio_q[1:0], sdio_i};
    end
  end

  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];
  assign active = ~csb_q[1] & ~csb_q[2];
  assign bit_in = sdio_q[2]; // data settled long before the rise, so the last stage is safe

  // frame engine: 16 instruction bits then one data byte, msb first
  always_comb begin
    next_cnt = cnt;
    next_instr = instr;
    next_rd = rd;
    next_load_pend = 1'b0;
    next_data_sh = data_sh;
    next_tx = tx;
    next_sdio = sdio_o;
    next_oe = sdio_oe_o;
    next_wr = 1'b0;
    next_addr = addr_o;
    next_wdata = wdata_o;
    if (!active) begin
      next_cnt = 5'h00;
      next_oe = 1'b0;
    end else begin
      if (load_pend) begin
        next_tx = rdata_i; // address settled a cycle ago
      end
      if (rise && cnt <= ACM_INSTR_LAST) begin
        next_instr = {instr[14:0], bit_in};
        next_cnt = 5'(cnt + 5'h01);
        if (cnt == ACM_INSTR_LAST) begin
          next_rd = instr[14];
          next_addr = {instr[11:0], bit_in};
          next_load_pend = instr[14];
        end
      end else if (rise && cnt <= ACM_DATA_LAST) begin
        next_data_sh = {data_sh[6:0], bit_in};
        next_cnt = 5'(cnt + 5'h01);
        if (cnt == ACM_DATA_LAST && !rd) begin
          next_wr = 1'b1;
          next_wdata = {data_sh[6:0], bit_in};
        end
      end
      // read data leaves on falling edges; bits past the byte are ignored
      if (fall && rd && cnt >= ACM_DATA_FIRST && cnt < ACM_FRAME_DONE) begin
        next_sdio = tx[7];
        next_tx = {tx[6:0], 1'b0};
        next_oe = 1'b1;
      end else if (fall && cnt >= ACM_FRAME_DONE) begin
        next_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 5'h00;
      instr <= 16'h0000;
      rd <= 1'b0;
      load_pend <= 1'b0;
      data_sh <= 8'h00;
      tx <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
      wr_o <= 1'b0;
      addr_o <= 13'h0000;
      wdata_o <= 8'h00;
    end else begin
      cnt <= next_cnt;
      instr <= next_instr;
      rd <= next_rd;
      load_pend <= next_load_pend;
      data_sh <= next_data_sh;
      tx <= next_tx;
      sdio_o <= next_sdio;
      sdio_oe_o <= next_oe;
      wr_o <= next_wr;
      addr_o <= next_addr;
      wdata_o <= next_wdata;
    end
  end

endmodule // acm_spi_port
`default_nettype wire

// file: verilog/acm_config_map.sv
// configuration register map reached over the serial control port
// Behaviour
// RULE1 - pattern one: 0x19 low, 0x1a high, zero reset
// RULE2 - pattern two: 0x1b low, 0x1c high, zero reset
// RULE3 - serial control resets 0x41; bit7 sends lsb first
// RULE4 - 0x22: bit1 output reset, bit0 power-down
// RULE5 - 0x100 enable plus code: 20/40/50/65 msps
// RULE6 - local writes hit selected channels; global all
// RULE7 - index low nibbles select data channels
// RULE8 - second index also selects clock outputs
// RULE9 - clock outputs take only power-down
// RULE10 - writes take effect at once except 0x100
// RULE11 - 0x100 loads only on transfer bit0
// RULE12 - 0x109 sync enable and next-only bits
// RULE13 - serial control bits1:0 pick 14 or 12 bits
`timescale 1ns/1ns
`default_nettype none
module acm_config_map
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output acm_cfg_t cfg_o,
  output logic [7:0] rate_msps_o
);

  logic wr;
  logic [12:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] idx_a, next_idx_a;
  logic [5:0] idx_b, next_idx_b;
  logic [7:0] rate_shadow, next_rate_shadow;
  logic [7:0] next_rate_msps;
  acm_cfg_t next_cfg;

  // channel select from both index registers
  function automatic logic [ACM_NCH-1:0] sel_mask(input logic [3:0] a, input logic [5:0] b);
    sel_mask = {b[ACM_IDX_DCO], b[ACM_IDX_FCO], b[3:0], a}; // RULE7 RULE8
  endfunction

  // rate code to msps; codes above 65 report zero
  function automatic logic [7:0] code_msps(input logic [2:0] code);
    if (code == ACM_RATE_20) begin
      code_msps = ACM_MSPS_20;
    end else if (code == ACM_RATE_40) begin
      code_msps = ACM_MSPS_40;
    end else if (code == ACM_RATE_50) begin
      code_msps = ACM_MSPS_50;
    end else if (code == ACM_RATE_65) begin
      code_msps = ACM_MSPS_65;
    end else begin
      code_msps = 8'h00;
    end
  endfunction

  acm_spi_port u_port (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sclk_i(sclk_i),
    .csb_n_i(csb_n_i),
    .sdio_i(sdio_i),
    .rdata_i(rdata),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o),
    .wr_o(wr),
    .addr_o(addr),
    .wdata_o(wdata)
  );

  // register writes; everything lands the cycle after the byte completes
  always_comb begin
    logic [ACM_NCH-1:0] mask;
    mask = sel_mask(idx_a, idx_b);
    next_cfg = cfg_o;
    next_idx_a = idx_a;
    next_idx_b = idx_b;
    next_rate_shadow = rate_shadow;
    if (wr) begin // RULE10
      if (addr == ACM_ADDR_INDEX_A) begin
        next_idx_a = wdata[3:0]; // RULE7
      end else if (addr == ACM_ADDR_INDEX_B) begin
        next_idx_b = wdata[5:0]; // RULE8
      end else if (addr == ACM_ADDR_PAT1_LO) begin
        next_cfg.pattern_one[7:0] = wdata; // RULE1
      end else if (addr == ACM_ADDR_PAT1_HI) begin
        next_cfg.pattern_one[15:8] = wdata; // RULE1
      end else if (addr == ACM_ADDR_PAT2_LO) begin
        next_cfg.pattern_two[7:0] = wdata; // RULE2
      end else if (addr == ACM_ADDR_PAT2_HI) begin
        next_cfg.pattern_two[15:8] = wdata; // RULE2
      end else if (addr == ACM_ADDR_SERIAL) begin
        next_cfg.serial = wdata; // RULE3 RULE6
      end else if (addr == ACM_ADDR_CHAN) begin
        for (int ch = 0; ch < ACM_NCH; ch++) begin
          if (mask[ch]) begin // RULE6
            next_cfg.chan_power_down[ch] = wdata[ACM_CH_POWER_DOWN]; // RULE4
            if (ch < ACM_NDATA) begin // RULE9
              next_cfg.chan_out_reset[ch] = wdata[ACM_CH_OUT_RESET]; // RULE4
            end
          end
        end
      end else if (addr == ACM_ADDR_RATE) begin
        next_rate_shadow = wdata & ACM_RATE_MASK; // held until transfer RULE11
      end else if (addr == ACM_ADDR_XFER) begin
        if (wdata[ACM_XFER_GO]) begin // RULE11
          next_cfg.rate_en = rate_shadow[ACM_RATE_EN]; // RULE5
          next_cfg.rate_code = rate_shadow[2:0]; // RULE5
        end
      end else if (addr == ACM_ADDR_IO_B) begin
        next_cfg.sdio_pull_off = wdata[ACM_IOB_PULL_OFF];
      end else if (addr == ACM_ADDR_IO_C) begin
        next_cfg.vcm_power_down = wdata[ACM_IOC_VCM_PD];
      end else if (addr == ACM_ADDR_SYNC) begin
        next_cfg.sync_enable = wdata[ACM_SYNC_EN]; // RULE12
        next_cfg.sync_next_only = wdata[ACM_SYNC_NEXT]; // RULE12
      end
    end
    // decoded views kept registered so outputs come from flops
    next_cfg.lsb_first = next_cfg.serial[ACM_SER_LSB_FIRST]; // RULE3
    next_cfg.res14 = (next_cfg.serial[1:0] == ACM_RES_14); // RULE13
    next_rate_msps = next_cfg.rate_en ? code_msps(next_cfg.rate_code) : 8'h00;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_o <= '{pattern_one: 16'h0000, pattern_two: 16'h0000, serial: ACM_RST_SERIAL,
                 lsb_first: 1'b0, res14: 1'b1, chan_out_reset: 10'h000,
                 chan_power_down: 10'h000, rate_en: 1'b0, rate_code: 3'h0,
                 sdio_pull_off: 1'b0, vcm_power_down: 1'b0, sync_enable: 1'b0,
                 sync_next_only: 1'b0}; // RULE1 RULE2 RULE3 RULE12
      idx_a <= ACM_RST_INDEX_A;
      idx_b <= ACM_RST_INDEX_B;
      rate_shadow <= ACM_RST_ZERO;
      rate_msps_o <= 8'h00;
    end else begin
      cfg_o <= next_cfg;
      idx_a <= next_idx_a;
      idx_b <= next_idx_b;
      rate_shadow <= next_rate_shadow;
      rate_msps_o <= next_rate_msps;
    end
  end

  // read mux; local register shows the lowest selected channel
  always_comb begin
    logic [ACM_NCH-1:0] mask;
    logic found;
    mask = sel_mask(idx_a, idx_b);
    found = 1'b0;
    rdata = 8'h00;
    if (addr == ACM_ADDR_INDEX_A) begin
      rdata = {4'h0, idx_a};
    end else if (addr == ACM_ADDR_INDEX_B) begin
      rdata = {2'h0, idx_b};
    end else if (addr == ACM_ADDR_PAT1_LO) begin
      rdata = cfg_o.pattern_one[7:0];
    end else if (addr == ACM_ADDR_PAT1_HI) begin
      rdata = cfg_o.pattern_one[15:8];
    end else if (addr == ACM_ADDR_PAT2_LO) begin
      rdata = cfg_o.pattern_two[7:0];
    end else if (addr == ACM_ADDR_PAT2_HI) begin
      rdata = cfg_o.pattern_two[15:8];
    end else if (addr == ACM_ADDR_SERIAL) begin
      rdata = cfg_o.serial;
    end else if (addr == ACM_ADDR_CHAN) begin
      for (int ch = 0; ch < ACM_NCH; ch++) begin
        if (mask[ch] && !found) begin
          found = 1'b1;
          rdata = {6'h00, cfg_o.chan_out_reset[ch], cfg_o.chan_power_down[ch]};
        end
      end
    end else if (addr == ACM_ADDR_RATE) begin
      rdata = rate_shadow; // shows what was written, not what is live
    end else if (addr == ACM_ADDR_IO_B) begin
      rdata = {7'h00, cfg_o.sdio_pull_off};
    end else if (addr == ACM_ADDR_IO_C) begin
      rdata = {4'h0, cfg_o.vcm_power_down, 3'h0};
    end else if (addr == ACM_ADDR_SYNC) begin
      rdata = {6'h00, cfg_o.sync_next_only, cfg_o.sync_enable};
    end
  end

  // checks on write effects
  pattern_one_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE1
    wr && addr == ACM_ADDR_PAT1_HI |=> cfg_o.pattern_one[15:8] == $past(wdata))
    else $error("pattern one high byte not stored");
  pattern_two_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE2
    wr && addr == ACM_ADDR_PAT2_LO |=> cfg_o.pattern_two[7:0] == $past(wdata))
    else $error("pattern two low byte not stored");
  lsb_first_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE3
    wr && addr == ACM_ADDR_SERIAL |=> cfg_o.lsb_first == $past(wdata[7]))
    else $error("bit order not taken from serial control");
  unselected_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE6
    wr && addr == ACM_ADDR_CHAN |=>
      ((cfg_o.chan_power_down ^ $past(cfg_o.chan_power_down))
       & ~sel_mask($past(idx_a), $past(idx_b))) == 10'h000)
    else $error("unselected channel changed");
  clock_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE9
    cfg_o.chan_out_reset[ACM_NCH-1:ACM_NDATA] == 2'h0)
    else $error("clock output took output reset");
  rate_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE11
    wr && addr == ACM_ADDR_RATE |=> $stable(cfg_o.rate_code) && $stable(cfg_o.rate_en))
    else $error("override went live without transfer");
  rate_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE5
    wr && addr == ACM_ADDR_XFER && wdata[0] |=>
      cfg_o.rate_code == $past(rate_shadow[2:0]) ##1
      rate_msps_o == (cfg_o.rate_en ? code_msps(cfg_o.rate_code) : 8'h00))
    else $error("transfer did not load override");
  sync_bits_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE12
    wr && addr == ACM_ADDR_SYNC |=> cfg_o.sync_enable == $past(wdata[0])
      && cfg_o.sync_next_only == $past(wdata[1]))
    else $error("sync bits not stored");
  resolution_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE13
    cfg_o.res14 == (cfg_o.serial[1:0] == 2'h1))
    else $error("resolution flag disagrees with serial control");

endmodule // acm_config_map
`default_nettype wire

// file: dv/acm_host.sv
// host model on the serial control port: frames one register write or read
`timescale 1ns/1ns
`default_nettype none
module acm_host (
  input wire logic clk_i,
  input wire logic sdio_i,
  output logic sclk_o,
  output logic csb_n_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  // both phases well over the 4-clock minimum so the 3-flop sync never misses an edge
  localparam int LOW_CLK = 6;
  localparam int HIGH_CLK = 5;

  // port idle: deselected, clock parked low, pin released
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  // 24-bit frame; data set while sclk low, device samples on the rise
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [23:0] word;
    word = {rd, 2'b00, addr, wdata};
    rdata = 8'h00;
    @(negedge clk_i);
    csb_n_o = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdio_oe_o = !(rd && i < 8); // release the pin for read data
      sdio_o = word[i];
      repeat (LOW_CLK) @(negedge clk_i);
      if (rd && i < 8) begin
        rdata[i] = sdio_i; // settled by now, taken just before the rise
      end
      sclk_o = 1'b1;
      repeat (HIGH_CLK) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    sdio_oe_o = 1'b0;
    @(negedge clk_i);
    csb_n_o = 1'b1;
    repeat (HIGH_CLK) @(negedge clk_i);
  endtask
endmodule // acm_host
`default_nettype wire

// file: dv/test_acm_config_map.sv
// self-checking bench for the converter configuration map
`timescale 1ns/1ns
`default_nettype none
module test_acm_config_map;
  import acm_pkg::*;
  logic clk = 1'b0;
  logic reset_n;
  logic sclk, csb_n, host_d, host_oe, dut_d, dut_oe;
  acm_cfg_t cfg;
  logic [7:0] msps;
  int fails = 0;
  int n_tests = 0;
  logic [12:0] reg_list [11] = '{ACM_ADDR_PAT1_LO, ACM_ADDR_PAT1_HI, ACM_ADDR_PAT2_LO,
    ACM_ADDR_PAT2_HI, ACM_ADDR_SERIAL, ACM_ADDR_CHAN, ACM_ADDR_RATE, ACM_ADDR_IO_B,
    ACM_ADDR_IO_C, ACM_ADDR_SYNC, ACM_ADDR_XFER};
  logic [7:0] msps_table [4] = '{ACM_MSPS_20, ACM_MSPS_40, ACM_MSPS_50, ACM_MSPS_65};

  // released pin sits low through the pull-down; with the pull switched off it floats high
  wire sdio_w = dut_oe ? dut_d : (host_oe ? host_d : cfg.sdio_pull_off);

  always #10 clk = ~clk;

  acm_config_map dut_u (.clk_i(clk), .reset_n_i(reset_n), .sclk_i(sclk), .csb_n_i(csb_n),
    .sdio_i(sdio_w), .sdio_o(dut_d), .sdio_oe_o(dut_oe), .cfg_o(cfg), .rate_msps_o(msps));
  acm_host host_u (.clk_i(clk), .sdio_i(sdio_w), .sclk_o(sclk), .csb_n_o(csb_n),
    .sdio_o(host_d), .sdio_oe_o(host_oe));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host_u.xfer(1'b0, a, d, unused);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host_u.xfer(1'b1, a, 8'h00, got);
    check($sformatf("read %h", a), {8'h00, got}, {8'h00, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] prev;
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check("pattern_one", cfg.pattern_one, 16'h0000);
    check("pattern_two", cfg.pattern_two, 16'h0000);
    check("serial", {8'h00, cfg.serial}, 16'h0041);
    check("res14", {15'h0000, cfg.res14}, 16'h0001);
    check("out_reset", {6'h00, cfg.chan_out_reset}, 16'h0000);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h0000);
    check("msps", {8'h00, msps}, 16'h0000);
    check("sync", {14'h0000, cfg.sync_enable, cfg.sync_next_only}, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      rd_chk(reg_list[i], (i == 4) ? ACM_RST_SERIAL : ACM_RST_ZERO);
    end
    // index first, then the local write reaches lane 0 only
    wr(ACM_ADDR_INDEX_A, 8'h01);
    wr(ACM_ADDR_INDEX_B, 8'h00);
    wr(ACM_ADDR_CHAN, 8'h03);
    check("out_reset", {6'h00, cfg.chan_out_reset}, 16'h0001);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h0001);
    rd_chk(ACM_ADDR_CHAN, 8'h03);
    // lane 7 plus both clock outputs: clocks take power-down only
    wr(ACM_ADDR_INDEX_A, 8'h00);
    wr(ACM_ADDR_INDEX_B, 8'h38);
    wr(ACM_ADDR_CHAN, 8'h03);
    check("out_reset", {6'h00, cfg.chan_out_reset}, 16'h0081);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h0381);
    wr(ACM_ADDR_CHAN, 8'h00);
    check("out_reset", {6'h00, cfg.chan_out_reset}, 16'h0001);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h0001);
    // global patterns ignore the narrow index; each byte lands alone
    wr(ACM_ADDR_PAT1_LO, 8'ha5);
    check("pattern_one", cfg.pattern_one, 16'h00a5);
    wr(ACM_ADDR_PAT1_HI, 8'h5a);
    check("pattern_one", cfg.pattern_one, 16'h5aa5);
    wr(ACM_ADDR_PAT2_LO, 8'h3c);
    wr(ACM_ADDR_PAT2_HI, 8'hc3);
    check("pattern_two", cfg.pattern_two, 16'hc33c);
    rd_chk(ACM_ADDR_PAT1_HI, 8'h5a);
    rd_chk(ACM_ADDR_PAT2_LO, 8'h3c);
    // bit order and every resolution code
    for (int c = 0; c < 4; c++) begin
      wr(ACM_ADDR_SERIAL, {6'h20, c[1:0]});
      check("lsb_first", {15'h0000, cfg.lsb_first}, 16'h0001);
      check("res14", {15'h0000, cfg.res14}, {15'h0000, (c == 1)});
    end
    wr(ACM_ADDR_SERIAL, 8'h41);
    check("lsb_first", {15'h0000, cfg.lsb_first}, 16'h0000);
    // override stays pending until the transfer bit
    for (int c = 0; c < 4; c++) begin
      prev = (c == 0) ? 8'h00 : msps_table[c - 1];
      wr(ACM_ADDR_RATE, {5'h08, c[2:0]});
      check("msps", {8'h00, msps}, {8'h00, prev});
      rd_chk(ACM_ADDR_RATE, {5'h08, c[2:0]});
      wr(ACM_ADDR_XFER, 8'h01);
      check("rate_en", {15'h0000, cfg.rate_en}, 16'h0001);
      check("rate_code", {13'h0000, cfg.rate_code}, {13'h0000, c[2:0]});
      check("msps", {8'h00, msps}, {8'h00, msps_table[c]});
    end
    rd_chk(ACM_ADDR_XFER, 8'h00);
    wr(ACM_ADDR_RATE, 8'h00);
    check("msps", {8'h00, msps}, {8'h00, ACM_MSPS_65});
    wr(ACM_ADDR_XFER, 8'h01);
    check("msps", {8'h00, msps}, 16'h0000);
    // transfer byte without bit 0 loads nothing; codes above 65 report zero
    wr(ACM_ADDR_RATE, 8'h47);
    wr(ACM_ADDR_XFER, 8'h02);
    check("rate_en", {15'h0000, cfg.rate_en}, 16'h0000);
    wr(ACM_ADDR_XFER, 8'h01);
    check("rate_code", {13'h0000, cfg.rate_code}, 16'h0007);
    check("msps", {8'h00, msps}, 16'h0000);
    // i/o control and sync bits
    wr(ACM_ADDR_IO_B, 8'h01);
    check("pull_off", {15'h0000, cfg.sdio_pull_off}, 16'h0001);
    rd_chk(ACM_ADDR_IO_B, 8'h01);
    wr(ACM_ADDR_IO_B, 8'h00);
    wr(ACM_ADDR_IO_C, 8'h08);
    check("vcm_pd", {15'h0000, cfg.vcm_power_down}, 16'h0001);
    rd_chk(ACM_ADDR_IO_C, 8'h08);
    wr(ACM_ADDR_SYNC, 8'h03);
    check("sync", {14'h0000, cfg.sync_enable, cfg.sync_next_only}, 16'h0003);
    wr(ACM_ADDR_SYNC, 8'h02);
    check("sync", {14'h0000, cfg.sync_enable, cfg.sync_next_only}, 16'h0001);
    rd_chk(ACM_ADDR_SYNC, 8'h02);
    // unmapped place: write dropped, read gives zero
    wr(13'h01d, 8'hff);
    rd_chk(13'h01d, 8'h00);
    check("pattern_one", cfg.pattern_one, 16'h5aa5);
    // reset in mid-run restores defaults and the all-lanes index
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check("pattern_one", cfg.pattern_one, 16'h0000);
    check("serial", {8'h00, cfg.serial}, 16'h0041);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h0000);
    wr(ACM_ADDR_CHAN, 8'h01);
    check("power_down", {6'h00, cfg.chan_power_down}, 16'h00ff);
    complete_run();
  end

  // watchdog: the run needs about 16k clocks, this allows about 75k
  initial begin
    #1_500_000;
    fails++;
    complete_run();
  end
endmodule // test_acm_config_map
`default_nettype wire
